// file: hdl/csa_core.sv
// cpu operating state control and logical address former
// Function
// RQ1: memory is addressed per byte, 64K ascending bytes per space or segment.
// RQ2: bit n within byte or word has weight two to the n.
// RQ3: multi-byte data sits at its lowest address, most significant byte first.
// RQ4: word and long accesses use even addresses; bytes any address.
// RQ5: nonsegmented variant drives a plain 16-bit byte address.
// RQ6: segmented variant drives 7-bit segment plus 16-bit offset.
// RQ7: offset arithmetic never carries into the segment number.
// RQ8: segmented address lives in a 32-bit long word container.
// RQ9: decoder accepts a 16-bit short encoding of segmented addresses.
// RQ10: nonsegmented code on segmented variant takes segment from program counter.
// RQ11: segment number goes out early, ahead of the offset.
// RQ12: exactly three operating states: running, stop/refresh, bus-disconnect.
// RQ13: stop or refresh demand enters stop/refresh, issuing only refresh cycles.
// RQ14: leave stop/refresh when neither condition remains, or on bus hold request.
// RQ15: on bus hold request grant, disconnect and release bus drivers, stay idle.
// RQ16: stay disconnected until the external master drops its request.
// RQ17: bus hold request outranks stop and refresh.
// RQ18: reset makes the device nonoperational within five cycles, held while asserted.
// RQ19: on reset release pick the state from bus hold request and stop levels.
// RQ20: after reset fetch flag control word and program counter from reserved area.
// RQ21: finish the bus transaction in progress before granting the bus.
`timescale 1ns/1ps
`default_nettype none
module csa_core #(
   parameter bit SEGMENTED = 1'b1
) (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              reset_pin_n,
   input  wire logic              stop_n,
   input  wire logic              bus_hold_request_n,
   input  wire logic              seg_mode,
   input  wire logic [6:0]        pc_seg,
   input  wire csa_pkg::csa_req_t exec_req,
   output logic                   exec_ready,
   input  wire logic [31:0]       long_word_register,
   input  wire logic [15:0]       word_register,
   input  wire logic              use_long,
   input  wire logic [15:0]       short_addr,
   input  wire logic [15:0]       displacement,
   output logic [22:0]            ea_long,
   output logic [22:0]            ea_short,
   output logic [22:0]            ea_plus_disp,
   output logic [31:0]            ea_container,
   input  wire logic [15:0]       mem_rdata,
   input  wire logic              mem_done,
   input  wire logic [3:0]        bit_sel,
   output logic [15:0]            bit_mask,
   output logic [15:0]            flag_control_word,
   output logic [15:0]            pc_offset_out,
   output logic [6:0]             pc_seg_out,
   output logic                   ps_loaded,
   output logic                   bus_hold_grant_n,
   output logic [6:0]             seg_out,
   output logic                   seg_oe_n,
   output logic [15:0]            addr_out,
   output logic                   addr_oe_n,
   output logic                   addr_strobe_n,
   output logic                   cyc_active,
   output logic                   cyc_write,
   output logic                   cyc_refresh,
   output logic                   addr_error,
   output logic [2:0]             op_state
);
   csa_pkg::csa_state_t state_r, state_nxt;

   // three-stage pin synchronisers; change counts when stages two and three agree
   localparam int N_PIN = 3;
   // reset pin starts seen as active so nothing runs before its level is known
   localparam logic [2:0] PIN_INIT = 3'b110;
   wire  [2:0] pin_raw = {bus_hold_request_n, stop_n, reset_pin_n};
   logic [2:0] pin_act;
   logic       rst_act_r, stop_act_r, breq_act_r;
   genvar g;
   generate
      for (g = 0; g < N_PIN; g++) begin : g_sync
         logic [2:0] sync_r;
         logic       act_r;
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               sync_r <= {3{PIN_INIT[g]}};
               act_r  <= ~PIN_INIT[g];
            end else begin
               sync_r <= {sync_r[1:0], pin_raw[g]};
               if (sync_r[1] == sync_r[2])
                  act_r <= ~sync_r[2];
            end
         end
         assign pin_act[g] = act_r;
      end
   endgenerate
   assign rst_act_r  = pin_act[0];
   assign stop_act_r = pin_act[1];
   assign breq_act_r = pin_act[2];

   // state decodes shared by the issue and output logic
   wire in_run     = (state_r == csa_pkg::CSA_ST_RUN);
   wire in_refresh = (state_r == csa_pkg::CSA_ST_REFRESH);

   // refresh demand counter; demand stays pending until a cycle in the refresh state serves it
   logic [6:0] ref_cnt_r;
   logic       ref_pend_r;
   wire        ref_tick  = (ref_cnt_r == 7'(csa_pkg::REFRESH_PERIOD - 1));
   wire        ref_serve = in_refresh && ref_pend_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_r  <= 7'h00;
         ref_pend_r <= 1'b0;
      end else begin
         ref_cnt_r <= ref_tick ? 7'h00 : ref_cnt_r + 7'h01;
         // new demand wins over the serve of the old one
         ref_pend_r <= ref_tick | (ref_pend_r & ~ref_serve);
      end
   end

   // program status fetch counter after reset
   logic [1:0]  ps_idx_r;
   logic        ps_loaded_r;
   logic [15:0] fcw_r, pc_off_r;
   logic [6:0]  pc_seg_r;
   logic        cyc_busy_r;
   wire         in_fetch  = (state_r == csa_pkg::CSA_ST_PSFETCH);
   wire         ps_last   = in_fetch && mem_done && (ps_idx_r == 2'(csa_pkg::PS_WORDS - 1));
   wire         want_stop = stop_act_r | ref_pend_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         csa_pkg::CSA_ST_RESET: begin
            if (!rst_act_r) begin // RQ19
               if (breq_act_r)
                  state_nxt = csa_pkg::CSA_ST_DISC;
               else if (stop_act_r)
                  state_nxt = csa_pkg::CSA_ST_REFRESH;
               else
                  state_nxt = ps_loaded_r ? csa_pkg::CSA_ST_RUN : csa_pkg::CSA_ST_PSFETCH;
            end
         end
         csa_pkg::CSA_ST_PSFETCH, csa_pkg::CSA_ST_RUN: begin
            if (breq_act_r) // RQ17
               state_nxt = cyc_busy_r ? csa_pkg::CSA_ST_DRAIN : csa_pkg::CSA_ST_DISC; // RQ21
            else if (want_stop && !cyc_busy_r)
               state_nxt = csa_pkg::CSA_ST_REFRESH; // RQ13
            else if (ps_last)
               state_nxt = csa_pkg::CSA_ST_RUN; // RQ20
         end
         csa_pkg::CSA_ST_REFRESH: begin
            if (breq_act_r)
               state_nxt = csa_pkg::CSA_ST_DISC; // RQ14 RQ17
            else if (!want_stop)
               state_nxt = ps_loaded_r ? csa_pkg::CSA_ST_RUN : csa_pkg::CSA_ST_PSFETCH; // RQ14
         end
         csa_pkg::CSA_ST_DRAIN: begin
            if (mem_done || !cyc_busy_r)
               state_nxt = csa_pkg::CSA_ST_DISC; // RQ21
         end
         csa_pkg::CSA_ST_DISC: begin
            if (!breq_act_r) // RQ16
               state_nxt = want_stop ? csa_pkg::CSA_ST_REFRESH :
                           (ps_loaded_r ? csa_pkg::CSA_ST_RUN : csa_pkg::CSA_ST_PSFETCH);
         end
         default: state_nxt = csa_pkg::CSA_ST_RESET;
      endcase
      if (rst_act_r) // RQ18
         state_nxt = csa_pkg::CSA_ST_RESET;
   end

   // segment early, offset one cycle later (RQ11)
   logic        early_r, cyc_wr_r, cyc_ref_r;
   logic [6:0]  seg_r;
   logic [15:0] off_r;
   logic [15:0] fetch_off;
   wire issue_ps  = in_fetch && !cyc_busy_r && !breq_act_r && !want_stop;
   wire align_bad = (exec_req.is_word | exec_req.is_long) & exec_req.addr.offset[0]; // RQ4
   wire run_ok    = in_run && !breq_act_r && !want_stop && !cyc_busy_r;
   wire issue_ex  = run_ok && exec_req.valid && !align_bad;
   wire issue_ref = in_refresh && !breq_act_r; // RQ13
   assign fetch_off  = csa_pkg::PS_AREA_BASE + {13'h0000, ps_idx_r, 1'b0};
   assign exec_ready = run_ok;
   // nonsegmented code still gets the program counter segment (RQ10)
   wire [6:0] ex_seg = !SEGMENTED ? 7'h00 : (seg_mode ? exec_req.addr.seg : pc_seg); // RQ5 RQ10

   // only the three operating states plus reset, fetch and drain substates
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         state_r <= csa_pkg::CSA_ST_RESET;
      else
         state_r <= state_nxt; // RQ12
   end

   // odd word or long request is refused and flagged one cycle later
   wire odd_refused = run_ok & exec_req.valid & align_bad; // RQ4
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         addr_error <= 1'b0;
      else
         addr_error <= odd_refused;
   end

   // issued cycle: busy until the memory answers, except refresh which is never busy; strobe for one cycle
   wire any_issue = issue_ref | issue_ps | issue_ex;
   wire busy_nxt  = any_issue ? ~issue_ref : (cyc_busy_r & ~mem_done);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_busy_r <= 1'b0;
         early_r    <= 1'b0;
      end else if (rst_act_r) begin
         cyc_busy_r <= 1'b0;
         early_r    <= 1'b0;
      end else begin
         cyc_busy_r <= busy_nxt;
         early_r    <= any_issue;
      end
   end

   // cycle attributes stand until the next issue
   wire [6:0]  seg_nxt = issue_ex ? ex_seg : csa_pkg::PS_AREA_SEG;
   wire [15:0] off_nxt = issue_ex ? exec_req.addr.offset : (issue_ps ? fetch_off : 16'h0000);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_wr_r  <= 1'b0;
         cyc_ref_r <= 1'b0;
         seg_r     <= 7'h00;
         off_r     <= 16'h0000;
      end else if (any_issue && !rst_act_r) begin
         cyc_wr_r  <= issue_ex & exec_req.wr;
         cyc_ref_r <= issue_ref;
         seg_r     <= seg_nxt;
         off_r     <= off_nxt;
      end
   end

   // status words land in order; a reset restarts the whole fetch
   wire ps_capture = in_fetch && mem_done && !rst_act_r && !any_issue;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ps_idx_r    <= 2'h0;
         ps_loaded_r <= 1'b0;
      end else if (rst_act_r) begin
         ps_idx_r    <= 2'h0;
         ps_loaded_r <= 1'b0;
      end else if (ps_capture) begin // RQ20
         ps_idx_r <= ps_idx_r + 2'h1;
         if (ps_last)
            ps_loaded_r <= 1'b1;
      end
   end

   // a drained fetch word is not captured, so it is fetched again later
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fcw_r    <= 16'h0000;
         pc_seg_r <= 7'h00;
         pc_off_r <= 16'h0000;
      end else if (ps_capture) begin
         unique case (ps_idx_r)
            2'h0: fcw_r <= mem_rdata;
            2'h1: pc_seg_r <= mem_rdata[14:8];
            default: pc_off_r <= mem_rdata;
         endcase
      end
   end

   // outputs float in disconnect and stay quiet while held in reset
   wire in_disc  = (state_r == csa_pkg::CSA_ST_DISC);
   wire in_reset = (state_r == csa_pkg::CSA_ST_RESET);
   wire driving  = !in_disc && !in_reset;
   assign bus_hold_grant_n = !in_disc; // RQ15
   assign seg_out          = SEGMENTED ? seg_r : 7'h00; // RQ6
   assign seg_oe_n         = !(driving && SEGMENTED); // RQ15
   assign addr_out         = early_r ? 16'h0000 : off_r; // RQ11
   assign addr_oe_n        = !driving; // RQ15
   assign addr_strobe_n    = !(driving && early_r);
   assign cyc_active       = cyc_busy_r | cyc_ref_r & early_r;
   assign cyc_write        = cyc_wr_r & cyc_busy_r;
   assign cyc_refresh      = cyc_ref_r & early_r;
   assign op_state         = state_r;
   assign flag_control_word = fcw_r;
   assign pc_offset_out    = pc_off_r;
   assign pc_seg_out       = pc_seg_r;
   assign ps_loaded        = ps_loaded_r;

   // address formation: segment field in bits 30:24 of the long container (RQ8)
   wire [6:0] long_seg  = long_word_register[csa_pkg::SEG_LSB_IN_LONG +: csa_pkg::SEG_W];
   // short form: bit 15 clear, segment in 14:8, 8-bit offset in 7:0 (RQ9)
   wire [6:0] short_seg = short_addr[csa_pkg::SHORT_LONG_FLAG-1:csa_pkg::SHORT_SEG_LSB];
   wire [22:0] ea_from_long = {long_seg, long_word_register[15:0]};
   wire [6:0]  word_seg     = SEGMENTED ? pc_seg : 7'h00;
   wire [22:0] ea_from_word = {word_seg, word_register};
   assign ea_long  = use_long ? ea_from_long : ea_from_word; // RQ8 RQ10
   assign ea_short = {short_seg, 8'h00, short_addr[7:0]}; // RQ9
   // offset wraps inside the segment; segment field never sees the carry (RQ7)
   wire [15:0] sum_off = ea_long[15:0] + displacement; // RQ1 RQ7
   assign ea_plus_disp = {ea_long[22:16], sum_off};
   assign ea_container = {1'b0, ea_long[22:16], 8'h00, ea_long[15:0]}; // RQ8
   // byte lane weight: bit n is 2**n, counted from the least significant end
   assign bit_mask = 16'h0001 << bit_sel; // RQ2 RQ3
endmodule
`default_nettype wire

// file: hdl/csa_pkg.sv
// package: states, address formats and timing for the cpu state and address unit
package csa_pkg;
   localparam int  CORE_CLK_HZ      = 25000000;
   localparam int  OFFSET_W         = 16;
   localparam int  SEG_W            = 7;
   localparam int  LADDR_W          = 23;
   localparam int  LONG_W           = 32;
   localparam int  SEG_LSB_IN_LONG  = 24;
   localparam int  SHORT_SEG_LSB    = 8;
   localparam int  SHORT_LONG_FLAG  = 15;
   localparam int  RESET_LIMIT_CYC  = 5;
   localparam int  RESET_CNT_W      = 3;
   localparam int  REFRESH_PERIOD   = 64;
   localparam int  REFRESH_CNT_W    = 7;
   localparam int  PS_WORDS         = 3;
   localparam logic [15:0] PS_AREA_BASE = 16'h0002;
   localparam logic [6:0]  PS_AREA_SEG  = 7'h00;

   typedef enum logic [2:0] {
      CSA_ST_RESET   = 3'b000,
      CSA_ST_PSFETCH = 3'b001,
      CSA_ST_RUN     = 3'b010,
      CSA_ST_REFRESH = 3'b011,
      CSA_ST_DRAIN   = 3'b100,
      CSA_ST_DISC    = 3'b101
   } csa_state_t;

   typedef struct packed {
      logic [6:0]  seg;
      logic [15:0] offset;
   } csa_laddr_t;

   typedef struct packed {
      logic        valid;
      logic        wr;
      logic        is_word;
      logic        is_long;
      csa_laddr_t  addr;
   } csa_req_t;
endpackage

// file: sim/csa_core_assertions.sv
// checker: state, grant and address timing of the cpu state unit
`timescale 1ns/1ps
`default_nettype none
module csa_core_assertions (
   input wire logic              core_clk,
   input wire logic              rstn,
   input wire logic              reset_pin_n,
   input wire logic              bus_hold_request_n,
   input wire csa_pkg::csa_req_t exec_req,
   input wire logic              exec_ready,
   input wire logic [3:0]        bit_sel,
   input wire logic [15:0]       bit_mask,
   input wire logic              bus_hold_grant_n,
   input wire logic              addr_oe_n,
   input wire logic              addr_strobe_n,
   input wire logic [15:0]       addr_out,
   input wire logic              cyc_active,
   input wire logic              cyc_write,
   input wire logic              cyc_refresh,
   input wire logic              addr_error,
   input wire logic [2:0]        op_state
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire odd_req = exec_req.valid && exec_req.addr.offset[0] && (exec_req.is_word || exec_req.is_long);
   // reset pin must be quiet too, its synchroniser lags the request
   sequence s_hold;
      (!bus_hold_request_n && reset_pin_n) [*4];
   endsequence
   sequence s_early;
      !addr_strobe_n && !cyc_refresh && addr_out == 16'h0;
   endsequence
   property p_refresh; op_state == 3'h3 |-> !cyc_write; endproperty
   a_refresh: assert property (p_refresh) else $error("write in refresh");
   property p_grant; !bus_hold_grant_n |-> addr_oe_n && !cyc_active && op_state == 3'h5; endproperty
   a_grant: assert property (p_grant) else $error("grant while driving");
   property p_grant_time; $fell(bus_hold_request_n) ##0 reset_pin_n |-> ##[1:60] !bus_hold_grant_n; endproperty
   a_grant_time: assert property (p_grant_time) else $error("grant late");
   property p_hold; s_hold ##0 op_state == 3'h5 |=> op_state == 3'h5; endproperty
   a_hold: assert property (p_hold) else $error("left disconnect");
   property p_reset; !reset_pin_n [*5] |=> op_state == 3'h0; endproperty
   a_reset: assert property (p_reset) else $error("reset late");
   property p_strobe; !addr_strobe_n && !cyc_refresh |-> s_early ##1 addr_strobe_n; endproperty
   a_strobe: assert property (p_strobe) else $error("offset early");
   property p_odd; odd_req && exec_ready |=> addr_error; endproperty
   a_odd: assert property (p_odd) else $error("odd not refused");
   property p_mask; bit_mask == 16'h1 << bit_sel; endproperty
   a_mask: assert property (p_mask) else $error("bit mask");
endmodule
bind csa_core csa_core_assertions csa_core_assertions_i (.core_clk, .rstn, .reset_pin_n,
   .bus_hold_request_n, .exec_req, .exec_ready, .bit_sel, .bit_mask, .bus_hold_grant_n,
   .addr_oe_n, .addr_strobe_n, .addr_out, .cyc_active, .cyc_write, .cyc_refresh,
   .addr_error, .op_state);
`default_nettype wire

// file: sim/csa_mem_model.sv
// memory partner: answers each non-refresh cycle after lat cycles with data ~offset
`timescale 1ns/1ps
`default_nettype none
module csa_mem_model (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        cyc_active,
   input  wire logic        cyc_refresh,
   input  wire logic        addr_strobe_n,
   input  wire logic [15:0] addr_out,
   input  wire logic [3:0]  lat,
   output logic             mem_done,
   output logic [15:0]      mem_rdata
);
   logic [3:0] cnt_r;
   // offset is valid only after the early cycle
   wire        busy = cyc_active && addr_strobe_n && !cyc_refresh && !mem_done;
   wire        fin  = busy && cnt_r == lat;
   // off the answer the data lines toggle so stale data never matches
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r     <= 4'h0;
         mem_done  <= 1'b0;
         mem_rdata <= 16'h0;
      end else begin
         mem_done  <= fin;
         mem_rdata <= fin ? ~addr_out : ~mem_rdata;
         cnt_r     <= (busy && !fin) ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// file: sim/test_cpu_state_and_address_unit.sv
// testbench: operating states and address forming of the cpu state unit
`timescale 1ns/1ps
`default_nettype none
module test_cpu_state_and_address_unit;
   logic              core_clk = 1'b0, rstn = 1'b0, reset_pin_n = 1'b1, stop_n = 1'b1;
   logic              bus_hold_request_n = 1'b1, seg_mode = 1'b0, use_long = 1'b0;
   logic [6:0]        pc_seg = 7'h00, pc_seg_out, seg_out;
   csa_pkg::csa_req_t exec_req = '0;
   logic [31:0]       long_word_register = 32'h0, ea_container;
   logic [15:0]       word_register = 16'h0, short_addr = 16'h0, displacement = 16'h0;
   logic [3:0]        bit_sel = 4'h0, lat = 4'h0;
   logic              exec_ready, mem_done, ps_loaded, bus_hold_grant_n, seg_oe_n, addr_oe_n;
   logic              addr_strobe_n, cyc_active, cyc_write, cyc_refresh, addr_error;
   logic [22:0]       ea_long, ea_short, ea_plus_disp, el, ra;
   logic [15:0]       mem_rdata, bit_mask, flag_control_word, pc_offset_out, addr_out;
   logic [2:0]        op_state;
   int                bad_count = 0, tests_run = 0, cyc = 0, i;
   csa_core csa_core_i (.core_clk, .rstn, .reset_pin_n, .stop_n, .bus_hold_request_n,
      .seg_mode, .pc_seg, .exec_req, .exec_ready, .long_word_register, .word_register,
      .use_long, .short_addr, .displacement, .ea_long, .ea_short, .ea_plus_disp, .ea_container,
      .mem_rdata, .mem_done, .bit_sel, .bit_mask, .flag_control_word, .pc_offset_out,
      .pc_seg_out, .ps_loaded, .bus_hold_grant_n, .seg_out, .seg_oe_n, .addr_out, .addr_oe_n,
      .addr_strobe_n, .cyc_active, .cyc_write, .cyc_refresh, .addr_error, .op_state);
   csa_mem_model csa_mem_model_i (.core_clk, .rstn, .cyc_active, .cyc_refresh,
      .addr_strobe_n, .addr_out, .lat, .mem_done, .mem_rdata);
   always #20 core_clk = ~core_clk;
   task stop_test;
      if (bad_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e, input string n);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // samples settled values at the falling edge, returns on a rising edge
   task wait_st(input logic [2:0] s);
      @(negedge core_clk);
      for (i = 0; i < 300 && op_state !== s; i++)
         @(negedge core_clk);
      chk(op_state, s, "op_state");
      @(posedge core_clk);
   endtask
   // one word access; segment follows pc when not in segmented mode
   task acc(input logic [6:0] sg, input logic [15:0] of, input logic w);
      exec_req <= '{1'b1, w, 1'b1, 1'b0, '{sg, of}};
      @(negedge core_clk);
      for (i = 0; i < 300 && exec_ready !== 1'b1; i++)
         @(negedge core_clk);
      @(posedge core_clk);
      exec_req <= '0;
      @(negedge core_clk);
      chk(addr_strobe_n, 1'b0, "addr_strobe_n");
      chk(seg_out, seg_mode ? sg : pc_seg, "seg_out");
      chk({cyc_active, cyc_write}, {1'b1, w}, "cyc_flags");
      @(negedge core_clk);
      chk(addr_out, of, "addr_out");
      for (i = 0; i < 50 && mem_done !== 1'b1; i++)
         @(negedge core_clk);
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 30000) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      void'($urandom(32'h7080));
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
      for (i = 0; i < 300 && ps_loaded !== 1'b1; i++)
         @(negedge core_clk);
      chk(ps_loaded, 1'b1, "ps_loaded");
      chk(flag_control_word, 16'hfffd, "fcw");
      chk({pc_seg_out, pc_offset_out}, {7'h7f, 16'hfff9}, "pc");
      @(posedge core_clk);
      for (int n = 0; n < 40; n++) begin
         {seg_mode, pc_seg, use_long, bit_sel, lat} <= 17'($urandom);
         long_word_register <= $urandom;
         {word_register, displacement} <= $urandom;
         short_addr <= 16'($urandom);
         ra = (n == 0) ? 23'h7ffffe : 23'($urandom);
         @(negedge core_clk);
         el = use_long ? {long_word_register[30:24], long_word_register[15:0]}
                       : {pc_seg, word_register};
         chk(ea_long, el, "ea_long");
         chk(ea_plus_disp, {el[22:16], el[15:0] + displacement}, "ea_plus_disp");
         chk(ea_container, {1'b0, el[22:16], 8'h00, el[15:0]}, "ea_container");
         chk(ea_short, {short_addr[14:8], 8'h00, short_addr[7:0]}, "ea_short");
         chk(bit_mask, 16'h0001 << bit_sel, "bit_mask");
         @(posedge core_clk);
         acc(ra[22:16], {ra[15:1], 1'b0}, ra[0]);
      end
      exec_req <= '{1'b1, 1'b0, 1'b1, 1'b0, '{ra[22:16], {ra[15:1], 1'b1}}};
      @(negedge core_clk);
      for (i = 0; i < 300 && addr_error !== 1'b1; i++)
         @(negedge core_clk);
      chk(addr_error, 1'b1, "addr_error");
      @(posedge core_clk);
      exec_req <= '0;
      stop_n <= 1'b0;
      wait_st(3'h3);
      @(negedge core_clk);
      for (i = 0; i < 10 && cyc_refresh !== 1'b1; i++)
         @(negedge core_clk);
      chk(cyc_refresh, 1'b1, "cyc_refresh");
      @(posedge core_clk);
      bus_hold_request_n <= 1'b0;
      wait_st(3'h5);
      @(negedge core_clk);
      chk({bus_hold_grant_n, addr_oe_n, seg_oe_n}, 3'h3, "grant_oe");
      repeat (20) @(negedge core_clk);
      chk(op_state, 3'h5, "op_state");
      @(posedge core_clk);
      bus_hold_request_n <= 1'b1;
      wait_st(3'h3);
      stop_n <= 1'b1;
      wait_st(3'h2);
      for (int k = 0; k < 2; k++) begin
         reset_pin_n <= 1'b0;
         stop_n <= k[0];
         bus_hold_request_n <= !k[0];
         repeat (5) @(posedge core_clk);
         @(negedge core_clk);
         chk(op_state, 3'h0, "op_state");
         @(posedge core_clk);
         reset_pin_n <= 1'b1;
         wait_st(k[0] ? 3'h5 : 3'h3);
         stop_n <= 1'b1;
         bus_hold_request_n <= 1'b1;
         wait_st(3'h2);
      end
      stop_test;
   end
endmodule
`default_nettype wire
